// ==== src/mcd_clk_div.sv ====
// programmable clock-out divider, output toggles on clk edges only
// assumes div_sel comes from a register on the same clock
`timescale 1ns/1ps
module mcd_clk_div
	import mcd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [4:0] div_sel,
	output logic            clk_out
);
	function automatic logic [5:0] div_of(input logic [4:0] s);
		div_of = (s == CKD_TOP) ? DIV_MIN : DIV_BASE - {1'b0, s};
	endfunction : div_of

	logic [5:0] n_reg;
	logic [5:0] n_next;
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	logic       out_reg;
	logic       out_next;
	logic       wrap;

	// ----------------------------------------------------------------
	// period counter
	// ----------------------------------------------------------------
	// odd factors give high one cycle longer than low
	always_comb
	begin
		wrap     = (cnt_reg == n_reg - 6'h01);
		cnt_next = wrap ? 6'h00 : cnt_reg + 6'h01;
		n_next   = wrap ? div_of(div_sel) : n_reg;
		out_next = (cnt_next < ((n_next + 6'h01) >> 1));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			n_reg   <= DIV_BASE;
			cnt_reg <= 6'h00;
			out_reg <= 1'b1;
		end
		else
		begin
			n_reg   <= n_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign clk_out = out_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] run_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			run_reg <= 6'h01;
		else
			run_reg <= (out_next != out_reg) ? 6'h01 : run_reg + 6'h01;
	end

	property p_hi_len;
		@(posedge clk) disable iff (rst)
		$fell(out_reg) |-> $past(run_reg) == ((n_reg + 6'h01) >> 1);
	endproperty
	a_hi_len : assert property (p_hi_len)
		else $error("clock-out high phase has wrong length");

	property p_lo_len;
		@(posedge clk) disable iff (rst)
		$rose(out_reg) && !$past(rst) |->
			$past(run_reg) == ($past(n_reg) >> 1);
	endproperty
	a_lo_len : assert property (p_lo_len)
		else $error("clock-out low phase has wrong length");

	property p_load_edge;
		@(posedge clk) disable iff (rst)
		!$stable(n_reg) |-> $rose(out_reg);
	endproperty
	a_load_edge : assert property (p_load_edge)
		else $error("divide factor changed inside a period");

	property p_top_code;
		@(posedge clk) disable iff (rst)
		div_sel == CKD_TOP && wrap |=> n_reg == DIV_MIN;
	endproperty
	a_top_code : assert property (p_top_code)
		else $error("top setting did not divide by two");
endmodule : mcd_clk_div

// ==== src/mcd_pkg.sv ====
// constants shared by the modem configuration block and its clock divider
// assumes a 100 MHz clk and an AXI4-Lite master with 12-bit byte addresses
package mcd_pkg;
	// ----------------------------------------------------------------
	// bus
	// ----------------------------------------------------------------
	localparam int         ADDR_W      = 12;
	localparam int         DATA_W      = 32;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] CKD_IDX  = 10'h044;
	localparam logic [9:0] MC0_IDX  = 10'h046;
	localparam logic [9:0] STAT_IDX = 10'h049;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MC0_RST  = 8'h45;
	localparam logic [4:0] CKD_RST  = 5'h00;
	localparam int         ZC_LSB   = 6;
	localparam int         ZC_MSB   = 7;
	localparam int         AVG_BIT  = 5;
	localparam int         PRE_LSB  = 1;
	localparam int         PRE_MSB  = 4;
	localparam int         FILT_BIT = 0;
	localparam logic [1:0] ZC_RSVD  = 2'h0;
	localparam logic [1:0] ZC_MAX   = 2'h3;
	localparam int         ST_LOCK  = 8;
	localparam int         ST_TXB   = 9;
	localparam int         ST_CLK   = 10;

	// ----------------------------------------------------------------
	// divider and preamble counts
	// ----------------------------------------------------------------
	localparam logic [4:0] CKD_TOP   = 5'h1f;
	localparam logic [5:0] DIV_BASE  = 6'h20;
	localparam logic [5:0] DIV_MIN   = 6'h02;
	localparam logic [5:0] PRE_EXTRA = 6'h02;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_PRE  = 1'b1
	} mcd_tx_e;
endpackage : mcd_pkg

// ==== src/mcd_top.sv ====
// modem configuration registers, sync search, offset averaging,
// preamble sequencer and clock-out divider behind an AXI4-Lite slave
// assumes symbol and offset strobes come from logic on clk
`timescale 1ns/1ps
module mcd_top
	import mcd_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [mcd_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [mcd_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [mcd_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [mcd_pkg::DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      sym_valid,
	input  wire logic                      sym_zero,
	input  wire logic                      sym_corr_hit,
	input  wire logic                      frame_end,
	input  wire logic                      fo_valid,
	input  wire logic [7:0]                fo_sample,
	output logic                           sync_found,
	output logic                           rx_locked,
	output logic [7:0]                     fo_level,
	input  wire logic                      tx_start,
	output logic                           tx_zero_valid,
	input  wire logic                      tx_zero_ready,
	output logic                           tx_pre_done,
	output logic                           tx_busy,
	output logic                           tx_filter_extra,
	output logic                           clk_out
);
	// ----------------------------------------------------------------
	// bus slave and registers
	// ----------------------------------------------------------------
	logic [9:0]  aw_idx_reg;
	logic [9:0]  aw_idx_next;
	logic        aw_hold_reg;
	logic        aw_hold_next;
	logic [7:0]  w_byte_reg;
	logic [7:0]  w_byte_next;
	logic        w_en_reg;
	logic        w_en_next;
	logic        w_hold_reg;
	logic        w_hold_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0]  mc0_reg;
	logic [7:0]  mc0_next;
	logic [4:0]  ckd_reg;
	logic [4:0]  ckd_next;
	logic        wr_go;
	logic [9:0]  ar_idx;
	logic [31:0] stat_word;
	mcd_tx_e     tx_state_reg;

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_go         = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

	always_comb
	begin
		stat_word                = 32'h0000_0000;
		stat_word[7:0]           = fo_level;
		stat_word[ST_LOCK]       = rx_locked;
		stat_word[ST_TXB]        = (tx_state_reg == TX_PRE);
		stat_word[ST_CLK]        = clk_out;
	end

	always_comb
	begin
		aw_idx_next  = aw_idx_reg;
		aw_hold_next = aw_hold_reg;
		w_byte_next  = w_byte_reg;
		w_en_next    = w_en_reg;
		w_hold_next  = w_hold_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		mc0_next     = mc0_reg;
		ckd_next     = ckd_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_idx_next  = s_axi_awaddr[ADDR_W-1:2];
			aw_hold_next = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_byte_next = s_axi_wdata[7:0];
			w_en_next   = s_axi_wstrb[0];
			w_hold_next = 1'b1;
		end
		if (wr_go)
		begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			case (aw_idx_reg)
				MC0_IDX: if (w_en_reg) mc0_next = w_byte_reg;
				CKD_IDX: if (w_en_reg) ckd_next = w_byte_reg[4:0];
				STAT_IDX: ;
				default: bresp_next = RESP_SLVERR;
			endcase
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			case (ar_idx)
				MC0_IDX:  rdata_next = {24'h00_0000, mc0_reg};
				CKD_IDX:  rdata_next = {27'h000_0000, ckd_reg};
				STAT_IDX: rdata_next = stat_word;
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_idx_reg  <= 10'h000;
			aw_hold_reg <= 1'b0;
			w_byte_reg  <= 8'h00;
			w_en_reg    <= 1'b0;
			w_hold_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
			mc0_reg     <= MC0_RST;
			ckd_reg     <= CKD_RST;
		end
		else
		begin
			aw_idx_reg  <= aw_idx_next;
			aw_hold_reg <= aw_hold_next;
			w_byte_reg  <= w_byte_next;
			w_en_reg    <= w_en_next;
			w_hold_reg  <= w_hold_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			mc0_reg     <= mc0_next;
			ckd_reg     <= ckd_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
	assign tx_filter_extra = mc0_reg[FILT_BIT];

	// ----------------------------------------------------------------
	// sync search and offset averaging
	// ----------------------------------------------------------------
	logic [1:0] zc_reg;
	logic [1:0] zc_next;
	logic       corr_reg;
	logic       corr_next;
	logic       sync_reg;
	logic       sync_next;
	logic       lock_reg;
	logic       lock_next;
	logic [7:0] lvl_reg;
	logic [7:0] lvl_next;
	logic [1:0] need;
	logic       avg_mode;
	logic [8:0] diff;
	logic [8:0] step;
	logic [8:0] sum;

	// reserved code 00 is treated like 01 rather than never syncing
	assign need     = (mc0_reg[ZC_MSB:ZC_LSB] == ZC_RSVD) ? 2'h1
		: mc0_reg[ZC_MSB:ZC_LSB];
	assign avg_mode = mc0_reg[AVG_BIT];

	always_comb
	begin
		zc_next   = zc_reg;
		corr_next = corr_reg;
		sync_next = 1'b0;
		lock_next = lock_reg;
		lvl_next  = lvl_reg;
		diff = {fo_sample[7], fo_sample} - {lvl_reg[7], lvl_reg};
		step = {diff[8], diff[8], diff[8:2]};
		sum  = {lvl_reg[7], lvl_reg} + step;
		if (sym_valid && sym_zero)
		begin
			zc_next   = (zc_reg == ZC_MAX) ? zc_reg : zc_reg + 2'h1;
			corr_next = corr_reg || sym_corr_hit;
		end
		else if (sym_valid)
		begin
			sync_next = (zc_reg >= need) && corr_reg;
			zc_next   = 2'h0;
			corr_next = 1'b0;
		end
		if (frame_end)
			lock_next = 1'b0;
		if (sync_next)
			lock_next = 1'b1;
		if (fo_valid && (avg_mode || !lock_reg))
			lvl_next = sum[7:0];
		if (frame_end && !avg_mode)
			lvl_next = 8'h00;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			zc_reg   <= 2'h0;
			corr_reg <= 1'b0;
			sync_reg <= 1'b0;
			lock_reg <= 1'b0;
			lvl_reg  <= 8'h00;
		end
		else
		begin
			zc_reg   <= zc_next;
			corr_reg <= corr_next;
			sync_reg <= sync_next;
			lock_reg <= lock_next;
			lvl_reg  <= lvl_next;
		end
	end

	assign sync_found = sync_reg;
	assign rx_locked  = lock_reg;
	assign fo_level   = lvl_reg;

	// ----------------------------------------------------------------
	// transmit preamble sequencer
	// ----------------------------------------------------------------
	mcd_tx_e    tx_state_next;
	logic [5:0] sym_left_reg;
	logic [5:0] sym_left_next;
	logic       done_reg;
	logic       done_next;
	logic [5:0] pre_syms;

	// two zero symbols per preamble byte
	assign pre_syms = ({2'h0, mc0_reg[PRE_MSB:PRE_LSB]} + PRE_EXTRA) << 1;

	always_comb
	begin
		tx_state_next = tx_state_reg;
		sym_left_next = sym_left_reg;
		done_next     = 1'b0;
		case (tx_state_reg)
			TX_IDLE:
				if (tx_start)
				begin
					sym_left_next = pre_syms;
					tx_state_next = TX_PRE;
				end
			TX_PRE:
				if (tx_zero_ready)
				begin
					sym_left_next = sym_left_reg - 6'h01;
					if (sym_left_reg == 6'h01)
					begin
						tx_state_next = TX_IDLE;
						done_next     = 1'b1;
					end
				end
			default: tx_state_next = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_state_reg <= TX_IDLE;
			sym_left_reg <= 6'h00;
			done_reg     <= 1'b0;
		end
		else
		begin
			tx_state_reg <= tx_state_next;
			sym_left_reg <= sym_left_next;
			done_reg     <= done_next;
		end
	end

	assign tx_zero_valid = (tx_state_reg == TX_PRE);
	assign tx_busy       = (tx_state_reg == TX_PRE);
	assign tx_pre_done   = done_reg;

	mcd_clk_div u_div (
		.clk     (clk),
		.rst     (rst),
		.div_sel (ckd_reg),
		.clk_out (clk_out)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] hlp_sent_reg;
	logic [5:0] hlp_len_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hlp_sent_reg <= 6'h00;
			hlp_len_reg  <= 6'h00;
		end
		else if (tx_state_reg == TX_IDLE && tx_start)
		begin
			hlp_sent_reg <= 6'h00;
			hlp_len_reg  <= pre_syms;
		end
		else if (tx_zero_valid && tx_zero_ready)
			hlp_sent_reg <= hlp_sent_reg + 6'h01;
	end

	property p_rst_val;
		@(posedge clk) $fell(rst) |-> mc0_reg == MC0_RST;
	endproperty
	a_rst_val : assert property (p_rst_val)
		else $error("modem control not at reset value");

	property p_filt_wr;
		@(posedge clk) disable iff (rst)
		wr_go && aw_idx_reg == MC0_IDX && w_en_reg |=>
			tx_filter_extra == $past(w_byte_reg[FILT_BIT]);
	endproperty
	a_filt_wr : assert property (p_filt_wr)
		else $error("filter select did not follow write");

	property p_sync_zeros;
		@(posedge clk) disable iff (rst)
		sync_found |-> $past(zc_reg) >= $past(need) && $past(zc_reg) != 2'h0;
	endproperty
	a_sync_zeros : assert property (p_sync_zeros)
		else $error("sync found with too few zeros");

	property p_sync_corr;
		@(posedge clk) disable iff (rst)
		sync_found |-> $past(corr_reg);
	endproperty
	a_sync_corr : assert property (p_sync_corr)
		else $error("sync found without a correlation hit");

	property p_freeze;
		@(posedge clk) disable iff (rst)
		lock_reg && !avg_mode && !frame_end |=> $stable(lvl_reg);
	endproperty
	a_freeze : assert property (p_freeze)
		else $error("level moved while frozen");

	property p_restart;
		@(posedge clk) disable iff (rst)
		frame_end && !avg_mode |=> lvl_reg == 8'h00 ##1
			(!lock_reg || sync_reg || $past(sync_reg));
	endproperty
	a_restart : assert property (p_restart)
		else $error("calibration did not restart after frame");

	property p_cont;
		@(posedge clk) disable iff (rst)
		avg_mode && fo_valid && fo_sample == 8'h40 && lvl_reg == 8'h00
			|=> lvl_reg == 8'h10;
	endproperty
	a_cont : assert property (p_cont)
		else $error("level not updated in continuous mode");

	property p_pre_len;
		@(posedge clk) disable iff (rst)
		tx_pre_done |-> hlp_sent_reg == hlp_len_reg && !tx_zero_valid;
	endproperty
	a_pre_len : assert property (p_pre_len)
		else $error("wrong number of preamble symbols");

	c_sync    : cover property (@(posedge clk) disable iff (rst) sync_found);
	c_tx_done : cover property (@(posedge clk) disable iff (rst) tx_pre_done);
	c_restart : cover property (@(posedge clk) disable iff (rst)
		lock_reg && frame_end && !avg_mode);
	c_slverr  : cover property (@(posedge clk) disable iff (rst)
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : mcd_top

// ==== verif/mcd_top_test.sv ====
// self-checking bench for the modem configuration block
// assumes mcd_top carries its own assertions; bench drives every port
`timescale 1ns/1ps
module mcd_top_test;
	import mcd_pkg::*;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam logic [11:0] A_MC0 = {MC0_IDX, 2'b00};
	localparam logic [11:0] A_CKD = {CKD_IDX, 2'b00};
	localparam logic [11:0] A_ST  = {STAT_IDX, 2'b00};
	logic              clk, rst, s_axi_awvalid, s_axi_awready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic              s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready, sym_valid, sym_zero;
	logic              sym_corr_hit, frame_end, fo_valid, sync_found;
	logic [7:0]        fo_sample, fo_level, mc0, lvl, v;
	logic              rx_locked, tx_start, tx_zero_valid, tx_zero_ready;
	logic              tx_pre_done, tx_busy, tx_filter_extra, clk_out;
	int                miscompares, checks, takes, syncs, n;
	logic [1:0]        bq[$];
	logic [33:0]       rq[$];
	int                tq[$];

	mcd_top u_mcd_top (
		.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sym_valid, .sym_zero,
		.sym_corr_hit, .frame_end, .fo_valid, .fo_sample, .sync_found,
		.rx_locked, .fo_level, .tx_start, .tx_zero_valid, .tx_zero_ready,
		.tx_pre_done, .tx_busy, .tx_filter_extra, .clk_out
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [33:0] seen,
		input logic [33:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// address and data offered together, released one by one
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bq.push_back(r);
		while (aw || w)
		begin
			@(posedge clk);
			if (aw && s_axi_awready)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid)
			@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rq.push_back({r, d});
		do
			@(posedge clk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge clk);
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic mc(input logic [7:0] d);
		mc0 = d;
		wr(A_MC0, d, 4'hf, RESP_OKAY);
	endtask : mc

	task automatic sym(input logic z, input logic h);
		@(posedge clk);
		sym_valid <= 1'b1;
		sym_zero <= z;
		sym_corr_hit <= h;
	endtask : sym

	// strobes are single-cycle, so drop all but tx_start before waiting
	task automatic idle(input int k);
		@(posedge clk);
		sym_valid <= 1'b0;
		frame_end <= 1'b0;
		fo_valid <= 1'b0;
		repeat (k) @(posedge clk);
	endtask : idle

	task automatic fe;
		@(posedge clk);
		frame_end <= 1'b1;
		idle(1);
	endtask : fe

	task automatic fo(input logic [7:0] s, input logic upd);
		int d;
		@(posedge clk);
		fo_valid <= 1'b1;
		fo_sample <= s;
		idle(1);
		d = $signed(s) - $signed(lvl);
		if (upd)
			lvl = lvl + 8'(d >>> 2);
		chk("fo_level", 34'(fo_level), 34'(lvl));
	endtask : fo

	// skip two rises so a fresh setting is surely in force
	task automatic meas(input int f);
		int hi;
		int lo;
		logic p;
		hi = 0;
		lo = 0;
		repeat (2)
		begin
			do
			begin
				p = clk_out;
				@(posedge clk);
			end
			while (p || !clk_out);
		end
		while (clk_out === 1'b1)
		begin
			hi++;
			@(posedge clk);
		end
		while (clk_out === 1'b0)
		begin
			lo++;
			@(posedge clk);
		end
		chk("clk_hi", 34'(hi), 34'((f + 1) / 2));
		chk("clk_lo", 34'(lo), 34'(f / 2));
	endtask : meas

	// ------------------------------------------------------------------
	// result monitor
	// ------------------------------------------------------------------
	always @(posedge clk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (tx_zero_valid && tx_zero_ready)
			takes++;
		if (tx_pre_done)
		begin
			chk("takes", 34'(takes), 34'(tq.pop_front()));
			takes = 0;
		end
		if (sync_found)
			syncs++;
	end

	initial
	begin
		#500000;
		miscompares++;
		end_sim();
	end

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{s_axi_arvalid, s_axi_rready, sym_valid, sym_zero} = 4'h0;
		{sym_corr_hit, frame_end, fo_valid, tx_start} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, tx_zero_ready} = 4'h0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		fo_sample = 8'h00;
		mc0 = MC0_RST;
		lvl = 8'h00;
		void'($urandom(1));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(A_MC0, 32'h0000_0045, RESP_OKAY);
		chk("filter", 34'(tx_filter_extra), 34'(1));
		rd(A_CKD, 32'h0000_0000, RESP_OKAY);
		rd(12'h004, 32'h0000_0000, RESP_SLVERR);
		wr(12'h004, 8'h5a, 4'hf, RESP_SLVERR);
		wr(A_ST, 8'hff, 4'hf, RESP_OKAY);
		v = {2'($urandom_range(1, 3)), 6'($urandom)};
		mc(v);
		wr(A_MC0, ~v, 4'he, RESP_OKAY);
		rd(A_MC0, {24'h0, v}, RESP_OKAY);
		chk("filter", 34'(tx_filter_extra), 34'(v[0]));
		$display("test registers done");
		meas(32);
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 3) ? 8'($urandom_range(0, 31)) : 8'(31 - i * 7);
			wr(A_CKD, v, 4'hf, RESP_OKAY);
			rd(A_CKD, {24'h0, v}, RESP_OKAY);
			meas((v == 8'd31) ? 2 : 32 - int'(v));
		end
		$display("test clock out done");
		for (int c = 1; c <= 3; c++)
		begin
			mc({c[1:0], mc0[5:0]});
			for (int k = 0; k < 3; k++)
			begin
				// one zero short, then no hit, then exactly enough
				syncs = 0;
				n = (k == 0) ? c - 1 : c;
				for (int i = 0; i < n; i++)
					sym(1'b1, k != 1 && i == n - 1);
				sym(1'b0, 1'b1);
				idle(2);
				chk("sync", 34'(syncs), 34'(k == 2));
				chk("lock", 34'(rx_locked), 34'(k == 2));
				fe();
			end
		end
		$display("test sync done");
		mc(mc0 & 8'hdf);
		fe();
		lvl = 8'h00;
		chk("fo_level", 34'(fo_level), 34'(0));
		mc(mc0 | 8'h20);
		fo(8'h40, 1'b1);
		repeat (2) fo(8'($urandom_range(0, 127)) - 8'd64, 1'b1);
		// lock first, so the next update proves mode 1 never freezes
		repeat (3) sym(1'b1, 1'b1);
		sym(1'b0, 1'b0);
		idle(2);
		chk("lock", 34'(rx_locked), 34'(1));
		fo(8'($urandom_range(0, 127)) - 8'd64, 1'b1);
		mc(mc0 & 8'hdf);
		fo(8'h30, 1'b0);
		fe();
		lvl = 8'h00;
		chk("fo_level", 34'(fo_level), 34'(0));
		fo(8'hc4, 1'b1);
		$display("test averaging done");
		for (int f = 0; f < 3; f++)
		begin
			v = (f == 2) ? 8'($urandom_range(0, 15)) : 8'(f * 15);
			mc({mc0[7:5], v[3:0], mc0[0]});
			tq.push_back(2 * (int'(v) + 2));
			@(posedge clk);
			tx_start <= 1'b1;
			n = 0;
			while (tq.size() > 0)
			begin
				@(posedge clk);
				n++;
				if (n == 2)
					chk("busy", 34'(tx_busy), 34'(1));
				tx_start <= (n == 3);
				tx_zero_ready <= 1'($urandom);
			end
		end
		chk("busy", 34'(tx_busy), 34'(0));
		$display("test preamble done");
		end_sim();
	end
endmodule : mcd_top_test
